//--- src/emu_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the emulator top; no other dependencies
`ifndef EMU_MAP_SVH
`define EMU_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the apb side)
// ----------------------------------------------------------------------
`define OFF_CTRL 16'h0000
`define OFF_WBADDR 16'h0004
`define OFF_DMASK 16'h0008
`define OFF_PMASK 16'h0010
`define OFF_DERR 16'h0014
`define OFF_HERR 16'h0018
`define OFF_BITL 16'h001C
`define OFF_BITH 16'h0020
`define OFF_EVCNT 16'h0024
`define OFF_RXL 16'h0028
`define OFF_GENL 16'h002C
`define OFF_RXH 16'h0030
`define OFF_GENH 16'h0034
`define OFF_ECODE 16'h0050
`define OFF_ECODE2 16'h0054
`define OFF_PKT 16'h0080
`define OFF_FAULT 16'h0094
`define OFF_THR 16'h00A0
`define OFF_RDTH 16'h00A4
`define OFF_BSTH 16'h00A8
`define OFF_AUX 16'h00AC
`define DESC_BASE 16'h4000
`define DESC_TOP 16'h41FF
`define PAT_BASE 16'h8000
`define PAT_TOP 16'h83FF

// ----------------------------------------------------------------------
// control and status field positions
// ----------------------------------------------------------------------
`define CB_START 0
`define CB_GEN 1
`define CB_STOPERR 2
`define CB_NOTIMER 3
`define CB_PRELOAD 7
`define CB_STEPENA 8
`define CB_STEP 11
`define CB_SRST 17
`define FB_CRC 0
`define FB_NOTRL 1
`define TB_OV 0
`define TB_OS 1
`define TB_BS 2
`define TB_RD 3
`define TB_SEL 4
`define DB_BAD_EVN 31
`define DB_BAD_CRC 30
`define HB_SRC_CRC 28
`define HB_LINK_CRC 30

// ----------------------------------------------------------------------
// reset values, frame marks and timing
// ----------------------------------------------------------------------
`define CTRL_RST 32'h0000_0000
`define HDR_MARK 8'h5A
`define TRL_MARK 8'hA5
`define DELAY_UNIT_NS 100
`define CLK_PERIOD_NS 10
`define DELAY_CYC ((`DELAY_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- src/emu_pkg.sv
// types used only by the event source emulator, not by its helpers
// assumes: nothing outside this package
package emu_pkg;

   // ----------------------------------------------------------------------
   // generation sequence, gray coded along idle-payload-trailer-wait
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_PAYLOAD = 2'b01,
      ST_TRAIL = 2'b11,
      ST_WAIT = 2'b10
   } gen_state_t;

   // ----------------------------------------------------------------------
   // whole register state of the top module, apart from the two memories
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [31:0] ctrl, wbaddr;
      logic [4:0] dmask;
      logic [7:0] pmask;
      logic [12:0] pkt;
      logic [4:0] thr;
      logic [7:0] rdth, bsth;
      logic aux, inj_crc, inj_notrl, step_pend;
      gen_state_t st;
      logic [4:0] didx;
      logic [20:0] words, wcnt;
      logic [12:0] pktcnt;
      logic [23:0] evnum;
      logic [15:0] crc;
      logic bad_crc, no_trl;
      logic [19:0] dly_units;
      logic [3:0] dly_pre;
      logic ev_valid, ev_first, ev_last, ev_pkt_end;
      logic [63:0] ev_data;
      logic [31:0] evcnt, derr, herr, bitl, bith, rxl, rxh, genl, genh;
      logic [31:0] ecode, ecode2;
      logic [4:0] chk_idx;
      logic [23:0] chk_evnum;
      logic [2:0] chk_hw;
      logic [7:0] fill;
      logic sync_err;
   } emu_state_t;

endpackage

//--- src/payload_if.sv
// carrier between the emulator and a pseudo-random payload generator
// assumes: both ends run on the same clock
`timescale 1ns/100ps
interface payload_if;
   logic load;
   logic [7:0] seed;
   logic step;
   logic [63:0] word;
   modport gen (input load, input seed, input step, output word);
   modport user (output load, output seed, output step, input word);
endinterface

//--- src/payload_prng.sv
// 64-bit xorshift payload generator, reseeded per event
// assumes: load and step never come together; load wins if they do
`timescale 1ns/100ps
module payload_prng
(
   input wire logic pclk,    // clock
   input wire logic presetn, // async reset, active low
   payload_if.gen pl         // seed, advance and current word
);
   logic [63:0] word_r;
   logic [63:0] word_nxt;

   // spreads an 8-bit seed; constant keeps a zero seed off the lock-up state
   always_comb
   begin
      word_nxt = word_r;
      if (pl.load)
         word_nxt = {8{pl.seed}} ^ 64'h9E37_79B9_7F4A_7C15;
      else if (pl.step)
      begin
         word_nxt = word_nxt ^ (word_nxt << 13);
         word_nxt = word_nxt ^ (word_nxt >> 7);
         word_nxt = word_nxt ^ (word_nxt << 17);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         word_r <= 64'h0;
      else
         word_r <= word_nxt;
   end

   assign pl.word = word_r;
endmodule

//--- src/throttle_status.sv
// throttle status outputs from fill thresholds and the sync error, or software override
// assumes: fill and thresholds are in the same unit (events outstanding)
`timescale 1ns/100ps
`include "emu_map.svh"
module throttle_status
(
   input wire logic pclk,          // clock
   input wire logic presetn,       // async reset, active low
   input wire logic [4:0] ctl,     // override bits and source select
   input wire logic [7:0] rd_th,   // ready threshold
   input wire logic [7:0] bs_th,   // busy threshold
   input wire logic [7:0] fill,    // current fill level
   input wire logic sync_err,      // header mismatch seen
   output logic overflow_output,   // overflow status
   output logic outsync_output,    // out-of-sync status
   output logic busy_output,       // busy status
   output logic ready_output       // ready status
);
   logic [3:0] st_r;
   logic [3:0] st_nxt;

   always_comb
   begin
      if (ctl[`TB_SEL])
         st_nxt = {ctl[`TB_RD], ctl[`TB_BS], ctl[`TB_OS], ctl[`TB_OV]};
      else
         st_nxt = {fill < rd_th, fill >= bs_th, sync_err, fill == 8'hFF};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= 4'h0;
      else
         st_r <= st_nxt;
   end

   assign overflow_output = st_r[0];
   assign outsync_output = st_r[1];
   assign busy_output = st_r[2];
   assign ready_output = st_r[3];
endmodule

//--- src/event_source_emulator.sv
// event source emulator: builds events from descriptors, checks write-back
// assumes: apb master on pclk; receive stream synchronous to pclk
`timescale 1ns/100ps
`include "emu_map.svh"
module event_source_emulator
(
   input wire logic pclk,           // clock, 100 MHz
   input wire logic presetn,        // async reset, active low
   input wire logic psel,           // apb select
   input wire logic penable,        // apb enable
   input wire logic pwrite,         // apb direction
   input wire logic [15:0] paddr,   // apb byte address
   input wire logic [31:0] pwdata,  // apb write data
   output logic [31:0] prdata,      // apb read data
   output logic pready,             // apb ready
   output logic pslverr,            // apb error, unmapped address
   output logic ev_valid,           // event word valid
   output logic ev_first,           // header word of an event
   output logic ev_last,            // trailer word of an event
   output logic ev_pkt_end,         // last word of a data packet
   output logic [63:0] ev_data,     // event word
   input wire logic rx_valid,       // write-back beat valid
   input wire logic rx_hdr,         // beat is a 32-bit header word
   input wire logic rx_last,        // last beat of a written-back event
   input wire logic [63:0] rx_data, // write-back beat
   output logic overflow_output,    // throttle overflow
   output logic outsync_output,     // throttle out of sync
   output logic busy_output,        // throttle busy
   output logic ready_output        // throttle ready
);
   import emu_pkg::*;

   emu_state_t s_r;
   emu_state_t s_nxt;
   logic [31:0] desc_mem [0:127];
   logic [63:0] pat_mem [0:127];
   payload_if gp ();
   payload_if cp ();

   logic acc, wr_fire, hit, is_pat, is_desc, go, err_d, err_h;
   logic [31:0] rd, w0, w1, w2, w3;
   logic [63:0] pw, tw;
   logic [20:0] wl;
   logic [6:0] ci;

   function automatic logic [15:0] fold(input logic [63:0] d);
      fold = d[15:0] ^ d[31:16] ^ d[47:32] ^ d[63:48];
   endfunction

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   payload_prng gen_prng
   (
      .pclk(pclk),
      .presetn(presetn),
      .pl(gp.gen)
   );

   payload_prng chk_prng
   (
      .pclk(pclk),
      .presetn(presetn),
      .pl(cp.gen)
   );

   throttle_status thr_out
   (
      .pclk(pclk),
      .presetn(presetn),
      .ctl(s_r.thr),
      .rd_th(s_r.rdth),
      .bs_th(s_r.bsth),
      .fill(s_r.fill),
      .sync_err(s_r.sync_err),
      .overflow_output(overflow_output),
      .outsync_output(outsync_output),
      .busy_output(busy_output),
      .ready_output(ready_output)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      acc = psel & penable;
      wr_fire = acc & s_r.pready & pwrite;
      is_pat = (paddr >= `PAT_BASE) && (paddr <= `PAT_TOP);
      is_desc = (paddr >= `DESC_BASE) && (paddr <= `DESC_TOP);
      hit = 1'b1;
      rd = 32'h0;
      w0 = desc_mem[{s_r.didx, 2'd0}];
      w1 = desc_mem[{s_r.didx, 2'd1}];
      w2 = desc_mem[{s_r.didx, 2'd2}];
      w3 = desc_mem[{s_r.didx, 2'd3}];
      ci = {s_r.chk_idx, 2'd0};
      wl = 21'((25'(w0[23:0]) + 25'h7) >> 3);
      go = (s_r.ctrl[`CB_START] & ~s_r.ctrl[`CB_STEPENA]) | s_r.step_pend;
      err_d = 1'b0;
      err_h = 1'b0;
      gp.load = 1'b0;
      gp.step = 1'b0;
      gp.seed = w1[23:16];
      cp.load = 1'b0;
      cp.step = 1'b0;
      cp.seed = desc_mem[ci + 7'd1][23:16];

      // payload source: preload walks the store, else generator or patterns
      if (s_r.ctrl[`CB_PRELOAD])
         pw = pat_mem[s_r.wcnt[6:0]];
      else if (s_r.ctrl[`CB_GEN])
         pw = gp.word;
      else
         pw = pat_mem[s_r.wcnt[6:0] & s_r.pmask[6:0]];
      tw = {`TRL_MARK, 8'h00, 3'h0, s_r.wcnt,
            s_r.bad_crc ? ~s_r.crc : s_r.crc, 8'h00};

      // apb: answer one cycle into the access phase
      s_nxt.pready = acc & ~s_r.pready;
      case (paddr)
         `OFF_CTRL: rd = s_r.ctrl;
         `OFF_WBADDR: rd = s_r.wbaddr;
         `OFF_DMASK: rd = {27'h0, s_r.dmask};
         `OFF_PMASK: rd = {24'h0, s_r.pmask};
         `OFF_DERR: rd = s_r.derr;
         `OFF_HERR: rd = s_r.herr;
         `OFF_BITL: rd = s_r.bitl;
         `OFF_BITH: rd = s_r.bith;
         `OFF_EVCNT: rd = s_r.evcnt;
         `OFF_RXL: rd = s_r.rxl;
         `OFF_GENL: rd = s_r.genl;
         `OFF_RXH: rd = s_r.rxh;
         `OFF_GENH: rd = s_r.genh;
         `OFF_ECODE: rd = s_r.ecode;
         `OFF_ECODE2: rd = s_r.ecode2;
         `OFF_PKT: rd = {16'h0, s_r.pkt, 3'h0};
         `OFF_FAULT: rd = 32'h0;
         `OFF_THR: rd = {27'h0, s_r.thr};
         `OFF_RDTH: rd = {24'h0, s_r.rdth};
         `OFF_BSTH: rd = {24'h0, s_r.bsth};
         `OFF_AUX: rd = {31'h0, s_r.aux};
         default:
         begin
            if (is_pat)
               rd = paddr[2] ? pat_mem[paddr[9:3]][63:32]
                             : pat_mem[paddr[9:3]][31:0];
            else if (is_desc)
               rd = desc_mem[paddr[8:2]];
            else
               hit = 1'b0;
         end
      endcase
      // error stands with pready only, never past the access
      s_nxt.pslverr = 1'b0;
      if (acc & ~s_r.pready)
      begin
         s_nxt.prdata = pwrite ? 32'h0 : rd;
         s_nxt.pslverr = ~hit;
      end

      // event generation
      s_nxt.ev_valid = 1'b0;
      s_nxt.ev_first = 1'b0;
      s_nxt.ev_last = 1'b0;
      s_nxt.ev_pkt_end = 1'b0;
      case (s_r.st)
         ST_IDLE:
         begin
            if (go)
            begin
               s_nxt.ev_valid = 1'b1;
               s_nxt.ev_first = 1'b1;
               s_nxt.ev_data = {`HDR_MARK,
                  w3[`DB_BAD_EVN] ? ~s_r.evnum : s_r.evnum,
                  4'h0, w2[11:0], 4'h0, w1[11:0]};
               s_nxt.crc = fold(s_nxt.ev_data);
               s_nxt.words = wl;
               s_nxt.wcnt = 21'h0;
               s_nxt.pktcnt = 13'h0;
               s_nxt.bad_crc = w3[`DB_BAD_CRC] | s_r.inj_crc;
               s_nxt.no_trl = s_r.inj_notrl;
               s_nxt.inj_crc = 1'b0;
               s_nxt.inj_notrl = 1'b0;
               s_nxt.step_pend = 1'b0;
               s_nxt.dly_units = s_r.ctrl[`CB_NOTIMER] ? 20'h0
                                                      : w2[31:12];
               gp.load = 1'b1;
               s_nxt.st = ST_PAYLOAD;
            end
         end
         ST_PAYLOAD:
         begin
            if (s_r.words == 21'h0)
               s_nxt.st = ST_TRAIL;
            else
            begin
               s_nxt.ev_valid = 1'b1;
               s_nxt.ev_data = pw;
               s_nxt.crc = s_r.crc ^ fold(pw);
               gp.step = s_r.ctrl[`CB_GEN] & ~s_r.ctrl[`CB_PRELOAD];
               s_nxt.wcnt = s_r.wcnt + 21'h1;
               s_nxt.words = s_r.words - 21'h1;
               s_nxt.pktcnt = s_r.pktcnt + 13'h1;
               if (s_r.pkt != 13'h0 && s_r.pktcnt + 13'h1 == s_r.pkt)
               begin
                  s_nxt.ev_pkt_end = 1'b1;
                  s_nxt.pktcnt = 13'h0;
               end
               if (s_r.words == 21'h1)
                  s_nxt.st = ST_TRAIL;
            end
         end
         ST_TRAIL:
         begin
            if (!s_r.no_trl)
            begin
               s_nxt.ev_valid = 1'b1;
               s_nxt.ev_last = 1'b1;
               s_nxt.ev_data = tw;
            end
            s_nxt.evnum = s_r.evnum + 24'h1;
            s_nxt.evcnt = s_r.evcnt + 32'h1;
            if (s_r.fill != 8'hFF)
               s_nxt.fill = s_r.fill + 8'h1;
            s_nxt.didx = (s_r.didx + 5'h1) & s_r.dmask;
            s_nxt.dly_pre = 4'h0;
            s_nxt.st = ST_WAIT;
         end
         ST_WAIT:
         begin
            // delay counted in 100 ns units of DELAY_CYC clocks each
            if (s_r.dly_units == 20'h0)
               s_nxt.st = ST_IDLE;
            else if (s_r.dly_pre == 4'(`DELAY_CYC - 1))
            begin
               s_nxt.dly_pre = 4'h0;
               s_nxt.dly_units = s_r.dly_units - 20'h1;
            end
            else
               s_nxt.dly_pre = s_r.dly_pre + 4'h1;
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // write-back checker, in-order events assumed
      if (rx_valid)
      begin
         if (rx_hdr)
         begin
            case (s_r.chk_hw)
               3'd0:
               begin
                  cp.load = 1'b1;
                  err_h = rx_data[11:0] != desc_mem[ci + 7'd1][11:0];
               end
               3'd1: err_h = rx_data[23:0] != s_r.chk_evnum;
               3'd4: err_h = rx_data[`HB_SRC_CRC] | rx_data[`HB_LINK_CRC];
               default: err_h = 1'b0;
            endcase
            if (s_r.chk_hw != 3'd5)
               s_nxt.chk_hw = s_r.chk_hw + 3'd1;
            if (err_h)
            begin
               s_nxt.herr = s_r.herr + 32'h1;
               s_nxt.sync_err = 1'b1;
               s_nxt.ecode = {27'h0, s_r.chk_hw, 2'b10};
            end
         end
         else
         begin
            s_nxt.rxl = rx_data[31:0];
            s_nxt.rxh = rx_data[63:32];
            s_nxt.genl = cp.word[31:0];
            s_nxt.genh = cp.word[63:32];
            if (s_r.ctrl[`CB_GEN] & ~s_r.ctrl[`CB_PRELOAD])
            begin
               cp.step = 1'b1;
               err_d = rx_data != cp.word;
            end
            if (err_d)
            begin
               s_nxt.derr = s_r.derr + 32'h1;
               s_nxt.bitl = rx_data[31:0] ^ cp.word[31:0];
               s_nxt.bith = rx_data[63:32] ^ cp.word[63:32];
               s_nxt.ecode = {27'h0, s_r.chk_hw, 2'b01};
               s_nxt.ecode2 = {11'h0, s_r.chk_idx, 16'h0};
            end
         end
         if (rx_last)
         begin
            s_nxt.chk_hw = 3'd0;
            s_nxt.chk_idx = (s_r.chk_idx + 5'h1) & s_r.dmask;
            s_nxt.chk_evnum = s_r.chk_evnum + 24'h1;
            if (s_nxt.fill != 8'h0)
               s_nxt.fill = s_nxt.fill - 8'h1;
         end
      end
      // event in flight completes; no new one is launched
      if ((err_d | err_h) & s_r.ctrl[`CB_STOPERR])
      begin
         s_nxt.ctrl[`CB_START] = 1'b0;
         s_nxt.step_pend = 1'b0;
      end

      // register writes last, so a write that lands with a launch is kept
      if (wr_fire)
      begin
         case (paddr)
            `OFF_CTRL:
            begin
               s_nxt.ctrl = pwdata & ~(32'h1 << `CB_SRST);
               if (pwdata[`CB_STEP] & pwdata[`CB_STEPENA])
                  s_nxt.step_pend = 1'b1;
            end
            `OFF_WBADDR: s_nxt.wbaddr = pwdata;
            `OFF_DMASK: s_nxt.dmask = pwdata[4:0];
            `OFF_PMASK: s_nxt.pmask = pwdata[7:0];
            `OFF_PKT: s_nxt.pkt = pwdata[15:3];
            `OFF_FAULT:
            begin
               s_nxt.inj_crc = s_nxt.inj_crc | pwdata[`FB_CRC];
               s_nxt.inj_notrl = s_nxt.inj_notrl | pwdata[`FB_NOTRL];
            end
            `OFF_THR: s_nxt.thr = pwdata[4:0];
            `OFF_RDTH: s_nxt.rdth = pwdata[7:0];
            `OFF_BSTH: s_nxt.bsth = pwdata[7:0];
            `OFF_AUX: s_nxt.aux = pwdata[0];
            default: s_nxt.aux = s_nxt.aux;
         endcase
         if (paddr == `OFF_CTRL && pwdata[`CB_SRST])
         begin
            // configuration other than ctrl, and both memories, survive a soft reset
            s_nxt.ctrl = `CTRL_RST;
            s_nxt.st = ST_IDLE;
            {s_nxt.step_pend, s_nxt.inj_crc, s_nxt.inj_notrl} = 3'h0;
            {s_nxt.didx, s_nxt.chk_idx, s_nxt.chk_hw} = 13'h0;
            {s_nxt.evnum, s_nxt.chk_evnum, s_nxt.fill} = 56'h0;
            {s_nxt.evcnt, s_nxt.derr, s_nxt.herr} = 96'h0;
            {s_nxt.bitl, s_nxt.bith, s_nxt.ecode, s_nxt.ecode2} = 128'h0;
            {s_nxt.rxl, s_nxt.rxh, s_nxt.genl, s_nxt.genh} = 128'h0;
            s_nxt.sync_err = 1'b0;
            {s_nxt.ev_valid, s_nxt.ev_first, s_nxt.ev_last} = 3'h0;
            s_nxt.ev_pkt_end = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // state and memories
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // no reset on the stores: contents are software's to load
   always_ff @(posedge pclk)
   begin
      if (wr_fire && is_pat)
      begin
         if (paddr[2])
            pat_mem[paddr[9:3]][63:32] <= pwdata;
         else
            pat_mem[paddr[9:3]][31:0] <= pwdata;
      end
      if (wr_fire && is_desc)
         desc_mem[paddr[8:2]] <= pwdata;
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign ev_valid = s_r.ev_valid;
   assign ev_first = s_r.ev_first;
   assign ev_last = s_r.ev_last;
   assign ev_pkt_end = s_r.ev_pkt_end;
   assign ev_data = s_r.ev_data;
endmodule

//--- testbench/emu_properties.sv
// port-level checks on the emulator's bus and event stream
// assumes: bound to the top, single clock domain
`timescale 1ns/100ps
module emu_properties
(
   input wire logic pclk,          // clock
   input wire logic presetn,       // reset, active low
   input wire logic psel,          // apb select
   input wire logic penable,       // apb enable
   input wire logic pwrite,        // apb direction
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready,        // apb ready
   input wire logic pslverr,       // apb error
   input wire logic ev_valid,      // event word valid
   input wire logic ev_first,      // header word
   input wire logic ev_last,       // trailer word
   input wire logic [63:0] ev_data // event word
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_wait;
      $rose(penable) && psel |=> pready;
   endproperty
   a_wait: assert property (p_wait) else $error("late ready");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long ready");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_wr;
      pready && pwrite |-> prdata == 32'h0;
   endproperty
   a_wr: assert property (p_wr) else $error("write data out");
   property p_hdr;
      ev_first |-> ev_valid && ev_data[63:56] == 8'h5A;
   endproperty
   a_hdr: assert property (p_hdr) else $error("bad header");
   property p_trl;
      ev_last |-> ev_valid && ev_data[63:56] == 8'hA5;
   endproperty
   a_trl: assert property (p_trl) else $error("bad trailer");
   property p_gap;
      ev_first |=> !ev_first [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("header too soon");
   property p_idle;
      ev_last |=> !ev_valid;
   endproperty
   a_idle: assert property (p_idle) else $error("no idle");
endmodule
bind event_source_emulator emu_properties chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .ev_valid, .ev_first,
   .ev_last, .ev_data);

//--- testbench/link_board_model.sv
// board under test: echoes each event back as a written-back block
// assumes: trailer beats are not written back
`timescale 1ns/100ps
module link_board_model
(
   input wire logic pclk,          // clock
   input wire logic presetn,       // reset, active low
   input wire logic ev_valid,      // event word valid
   input wire logic ev_first,      // header word
   input wire logic ev_last,       // trailer word
   input wire logic [63:0] ev_data, // event word
   input wire logic crc_bad,       // flag source crc error
   output logic rx_valid,          // beat valid
   output logic rx_hdr,            // header beat
   output logic rx_last,           // last beat
   output logic [63:0] rx_data     // beat data
);
   logic [65:0] q[$];
   logic [65:0] b;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q.delete();
         {rx_valid, rx_hdr, rx_last, rx_data} <= '0;
      end
      else
      begin
         if (ev_valid && ev_first)
         begin
            q.push_back({2'b10, 52'h0, ev_data[11:0]});
            q.push_back({2'b10, 40'h0, ev_data[55:32]});
            q.push_back({2'b10, 64'h0});
            q.push_back({2'b10, 64'h0});
            q.push_back({2'b10, 32'h0, 3'b100, crc_bad, 28'h0});
         end
         else if (ev_valid && !ev_last)
            q.push_back({2'b00, ev_data});
         else if (ev_valid)
            q[$][64] = 1'b1;
         rx_valid <= q.size() > 0;
         if (q.size() > 0)
         begin
            b = q.pop_front();
            {rx_hdr, rx_last, rx_data} <= b;
         end
         else
         begin
            {rx_hdr, rx_last} <= 2'b00;
            rx_data <= ~rx_data; // idle: inverted, no stale value
         end
      end
   end
endmodule

//--- testbench/test_event_source_emulator.sv
// self-checking bench for the event source emulator
// assumes: link board model echoes every event back
`timescale 1ns/100ps
module test_event_source_emulator;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bad = 0;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, ev_valid, ev_first, ev_last, ev_pkt_end;
   logic rx_valid, rx_hdr, rx_last;
   logic [63:0] ev_data, rx_data, hdr;
   logic overflow_output, outsync_output, busy_output, ready_output;
   int failures = 0, tests_run = 0, nf = 0, nl = 0, np = 0, i;
   logic [15:0] ra[8] = '{16'h0008, 16'h0010, 16'h0080, 16'h00A4, 16'h00A8,
      16'h0024, 16'h0014, 16'h8004};
   logic [31:0] rw[8] = '{32'h1F, 32'hFF, 32'hFFFF, 32'h1A5, 32'h33,
      32'h5, 32'h1, 32'h1234_5678};
   logic [31:0] re[8] = '{32'h1F, 32'hFF, 32'hFFF8, 32'hA5, 32'h33,
      32'h0, 32'h0, 32'h1234_5678};
   initial forever #5 pclk = ~pclk;
   event_source_emulator DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .ev_valid, .ev_first,
      .ev_last, .ev_pkt_end, .ev_data, .rx_valid, .rx_hdr, .rx_last,
      .rx_data, .overflow_output, .outsync_output, .busy_output,
      .ready_output);
   link_board_model board (.pclk, .presetn, .ev_valid, .ev_first, .ev_last,
      .ev_data, .crc_bad(bad), .rx_valid, .rx_hdr, .rx_last, .rx_data);
   always @(posedge pclk)
   begin
      if (ev_first === 1'b1)
         hdr <= ev_data;
      nf <= nf + (ev_first === 1'b1);
      nl <= nl + (ev_last === 1'b1);
      np <= np + (ev_pkt_end === 1'b1);
   end
   task test_done;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   // called just after a rising edge; returns one edge after release
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk);
      while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      er = pslverr;
      if (n == 20)
      begin
         failures++;
         $display("FAIL %0t no pready", $time);
         test_done;
      end
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task rdchk(input logic [15:0] a, input logic [31:0] e);
      apb(0, a, '0);
      chk(rd, e);
   endtask
   task thr(input logic [3:0] e);
      repeat (2) @(posedge pclk);
      chk({overflow_output, outsync_output, busy_output, ready_output}, e);
   endtask
   task step;
      apb(1, 16'h0000, 32'h902);
      repeat (40) @(posedge pclk);
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (i = 0; i < 8; i++)
      begin
         apb(1, ra[i], rw[i]);
         rdchk(ra[i], re[i]);
      end
      apb(0, 16'h0060, '0);
      chk({31'h0, er}, 32'h1);
      apb(1, 16'h00A0, 32'h1B);
      thr(4'b1101);
      apb(1, 16'h00A0, 32'h14);
      thr(4'b0010);
      apb(1, 16'h00A0, 32'h0);
      thr(4'b0001);
      apb(1, 16'h0008, '0);
      apb(1, 16'h0080, 32'h8);
      apb(1, 16'h4000, 32'h10);
      apb(1, 16'h4004, 32'h005C0123);
      apb(1, 16'h4008, 32'h00001007);
      apb(1, 16'h400C, '0);
      step();
      chk(nf, 1);
      chk(np, 2);
      chk({20'h0, hdr[11:0]}, 32'h123);
      chk({20'h0, hdr[27:16]}, 32'h7);
      rdchk(16'h0024, 32'h1);
      rdchk(16'h0014, '0);
      rdchk(16'h0018, '0);
      bad <= 1;
      step();
      bad <= 0;
      rdchk(16'h0018, 32'h1);
      apb(1, 16'h0094, 32'h2);
      i = nl;
      step();
      chk(nl, i);
      rdchk(16'h0024, 32'h3);
      apb(1, 16'h0000, 32'h20000);
      rdchk(16'h0024, '0);
      rdchk(16'h0010, 32'hFF);
      i = nf;
      apb(1, 16'h0000, 32'h3);
      repeat (60) @(posedge pclk);
      apb(1, 16'h0000, 32'h0);
      repeat (40) @(posedge pclk);
      chk({31'h0, nf > i + 1}, 32'h1);
      rdchk(16'h0014, '0);
      test_done;
   end
endmodule
